/* design/pba_pkg.sv */
`default_nettype none
package pba_pkg;
    // Number of external secondary masters; the bridge is one more entry.
    localparam int PBA_EXT_MASTERS = 9;
    localparam int PBA_ALL_MASTERS = PBA_EXT_MASTERS + 1;
    // Index of the bridge itself in the priority vector.
    localparam int PBA_BRIDGE_IDX = PBA_EXT_MASTERS;
    // Grant timeout while the bus stays idle, in cycles.
    localparam int PBA_NOSTART_CYCLES = 16;
    localparam int PBA_TMO_W = 5;
    // Reset value of the group bits: externals low, bridge high.
    localparam logic [PBA_ALL_MASTERS-1:0] PBA_GROUP_RST = 10'h200;
    // Register map of the plain register port.
    localparam int PBA_ADDR_W = 4;
    localparam logic [PBA_ADDR_W-1:0] PBA_REG_GROUP = 4'h0;
    localparam logic [PBA_ADDR_W-1:0] PBA_REG_STATUS = 4'h1;
    localparam logic [PBA_ADDR_W-1:0] PBA_REG_OWNER = 4'h2;
    // Encoding of "no owner" in the owner index.
    localparam logic [3:0] PBA_NO_OWNER = 4'hf;
    // Secondary arbiter states.
    typedef enum logic [1:0] {PBA_S_IDLE, PBA_S_GAP, PBA_S_GRANT} pba_sarb_t;
    // Primary requester states.
    typedef enum logic [1:0] {PBA_P_IDLE, PBA_P_REQ, PBA_P_RUN} pba_preq_t;
endpackage
`default_nettype wire

/* design/pba_arb_if.sv */
`default_nettype none
// ============================================================
// Request and grant vectors between the top and the secondary arbiter.
interface pba_arb_if #(parameter int N = 10);
    logic [N-1:0] req;      // Active-high requests, bridge in the top bit.
    logic [N-1:0] group;    // One bit per master: 1 high group.
    logic [N-1:0] gnt;      // One-hot or all-zero grant, registered.
    logic start;            // Secondary frame seen starting a transaction.
    logic busy;             // Secondary frame or initiator-ready asserted.
    logic [3:0] owner;      // Last initiator index.
    modport arb (input req, group, start, busy, output gnt, owner);
    modport top (output req, group, start, busy, input gnt, owner);
endinterface
`default_nettype wire

/* design/pba_sec_arb.sv */
`default_nettype none
// ============================================================
// Two-level rotating secondary arbiter with timeout and parking.
module pba_sec_arb
    import pba_pkg::*;
#(
    parameter int N = PBA_ALL_MASTERS
)
(
    input wire logic ref_clk, // Bus clock.
    input wire logic nrst,    // Asynchronous reset, active low.
    pba_arb_if.arb a          // Requests in, grants out.
);
    initial
    begin
        if (N < 2 || N > 15)
            $error("pba_sec_arb: N out of range");
    end

    logic [N-1:0] gnt_r, gnt_nxt;          // Current grant vector.
    logic [3:0] last_r, last_nxt;          // Last initiator.
    logic [3:0] lo_last_r, lo_last_nxt;    // Last low-group initiator.
    logic [PBA_TMO_W-1:0] tmo_r, tmo_nxt;  // Idle grant cycles.
    logic [N-1:0] block_r, block_nxt;      // Masters barred after timeout.
    pba_sarb_t st_r, st_nxt;
    logic [N-1:0] elig;                    // Requests allowed to win.
    logic [3:0] win;                       // Winner index or no owner.
    logic found;

    // Pick a winner from a rotating start; the low group counts as one slot.
    function automatic logic [3:0] pick(input logic [N-1:0] r, input logic [N-1:0] g,
                                        input logic [3:0] last, input logic [3:0] lolast);
        logic [3:0] res;
        logic [3:0] idx;
        logic mixed;
        logic lo_hit;
        logic [3:0] lo_w;
        res = PBA_NO_OWNER;
        lo_w = PBA_NO_OWNER;
        mixed = (|g) && !(&g);
        lo_hit = 1'b0;
        // Low-group candidate rotates evenly from the last low winner.
        for (int k = 1; k <= N; k++)
        begin
            idx = 4'((int'(lolast) + k) % N);
            if (!lo_hit && r[idx] && !g[idx])
            begin
                lo_hit = 1'b1;
                lo_w = idx;
            end
        end
        // High ring walks after the last initiator, low group taking the slot
        // that comes just before the bridge position.
        for (int k = 1; k <= N; k++)
        begin
            idx = 4'((int'(last) + k) % N);
            if (res == PBA_NO_OWNER)
            begin
                // The low slot sits just ahead of the bridge and is skipped
                // right after a low member, so the groups alternate fairly.
                if (!mixed && r[idx])
                    res = idx;
                else if (mixed && idx == 4'(PBA_BRIDGE_IDX) && g[last] && lo_hit)
                    res = lo_w;
                else if (mixed && g[idx] && r[idx])
                    res = idx;
            end
        end
        if (res == PBA_NO_OWNER && lo_hit)
            res = lo_w;
        return res;
    endfunction

    always_comb
    begin
        elig = a.req & ~block_r;
        win = pick(elig, a.group, last_r, lo_last_r); // (R9) (R10) (R14)
        found = (win != PBA_NO_OWNER);
    end

    // Next-state logic for grants, rotation, timeout and blocking.
    always_comb
    begin
        gnt_nxt = gnt_r;
        last_nxt = last_r;
        lo_last_nxt = lo_last_r;
        tmo_nxt = tmo_r;
        st_nxt = st_r;
        // A barred master is freed once its request has dropped for a clock.
        block_nxt = block_r & a.req; // (R15)
        // Reevaluate on each transaction start: the granted one initiated.
        if (a.start && |gnt_r) // (R12)
        begin
            for (int i = 0; i < N; i++)
            begin
                if (gnt_r[i])
                begin
                    last_nxt = 4'(i); // (R14)
                    if (!a.group[i])
                        lo_last_nxt = 4'(i);
                end
            end
        end
        // Idle grant counter for the no-start timeout.
        if (|gnt_r && !a.busy && !a.start && !gnt_r[PBA_BRIDGE_IDX])
            tmo_nxt = tmo_r + 1'b1;
        else
            tmo_nxt = '0;
        case (st_r)
            PBA_S_GRANT:
            begin
                if (tmo_r == PBA_TMO_W'(PBA_NOSTART_CYCLES - 1) && !a.busy && !a.start)
                begin
                    // Withdraw and bar the silent master.
                    block_nxt = block_r | gnt_r; // (R15)
                    gnt_nxt = '0;
                    st_nxt = PBA_S_GAP;
                end
                else if (found && !gnt_r[win])
                begin
                    // Higher winner appears: swap now if busy, else leave a gap.
                    if (a.busy) // (R16)
                        gnt_nxt = N'(1) << win; // (R13)
                    else
                    begin
                        gnt_nxt = '0; // (R16)
                        st_nxt = PBA_S_GAP;
                    end
                end
                // Otherwise keep the grant parked at the last user. (R20)
            end
            PBA_S_GAP:
            begin
                if (found)
                begin
                    gnt_nxt = N'(1) << win; // (R21)
                    st_nxt = PBA_S_GRANT;
                end
                else
                    st_nxt = PBA_S_IDLE;
            end
            PBA_S_IDLE:
            begin
                if (found)
                begin
                    gnt_nxt = N'(1) << win;
                    st_nxt = PBA_S_GRANT;
                end
            end
            default:
            begin
                st_nxt = PBA_S_IDLE;
                gnt_nxt = '0;
            end
        endcase
    end

    // Registers; after reset the bus is parked at the bridge.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gnt_r <= N'(1) << PBA_BRIDGE_IDX; // (R20)
            st_r <= PBA_S_GRANT;
            last_r <= 4'(PBA_BRIDGE_IDX);
            lo_last_r <= 4'(N - 1);
            tmo_r <= '0;
            block_r <= '0;
        end
        else
        begin
            gnt_r <= gnt_nxt;
            st_r <= st_nxt;
            last_r <= last_nxt;
            lo_last_r <= lo_last_nxt;
            tmo_r <= tmo_nxt;
            block_r <= block_nxt;
        end
    end

    assign a.gnt = gnt_r;
    assign a.owner = last_r;

    a_gnt_onehot: assert property (@(posedge ref_clk) disable iff (!nrst) $onehot0(gnt_r)) // (R21)
        else $error("more than one secondary grant");
    a_idle_gap: assert property (@(posedge ref_clk) disable iff (!nrst)
        (|gnt_r && !a.busy && gnt_nxt != gnt_r && |gnt_nxt) |-> (gnt_r == '0)) // (R16)
        else $error("grant swapped on idle bus");
    a_tmo_drop: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tmo_r == PBA_TMO_W'(PBA_NOSTART_CYCLES - 1) && !a.busy && !a.start) |=> (gnt_r == '0)) // (R15)
        else $error("timeout did not withdraw grant");
    a_blocked: assert property (@(posedge ref_clk) disable iff (!nrst) (gnt_r & block_r) == '0) // (R15)
        else $error("barred master granted");
endmodule // pba_sec_arb
`default_nettype wire

/* design/pba_park_drv.sv */
`default_nettype none
// ============================================================
// Parking driver enables: address and command first, parity a cycle later.
module pba_park_drv
(
    input wire logic ref_clk, // Bus clock.
    input wire logic nrst,    // Asynchronous reset, active low.
    input wire logic park,    // Parking condition this cycle.
    output logic ad_oe,       // Address/command enable, registered.
    output logic par_oe       // Parity enable, registered.
);
    logic ad_nxt, par_nxt;

    always_comb
    begin
        ad_nxt = park;
        par_nxt = park && ad_oe; // (R7)
    end

    // Dropping park releases both drivers on the next clock.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ad_oe <= 1'b0;
            par_oe <= 1'b0;
        end
        else
        begin
            ad_oe <= ad_nxt;
            par_oe <= par_nxt;
        end
    end

    a_par_late: assert property (@(posedge ref_clk) disable iff (!nrst) $rose(ad_oe) |-> !par_oe ##1 (par_oe || !ad_oe)) // (R7)
        else $error("parity driven with address");
endmodule // pba_park_drv
`default_nettype wire

/* design/pba_top.sv */
`default_nettype none
// Behaviour
// (R1) Posted upstream write: request one cycle after devsel.
// (R2) Delayed request: wait until queued, retried, head.
// (R3) Grant after request: start next cycle.
// (R4) Park primary only granted, not requesting, idle.
// (R5) Grant lost while parking: release next cycle.
// (R6) Parked with work: frame next clock if granted.
// (R7) Park drives address/command first, parity next.
// (R8) Strap low: internal arbiter, nine masters plus bridge.
// (R9) Two-level rotation, low group one slot.
// (R10) Per-master group bit; single group plain rotation.
// (R11) Reset: externals low group, bridge high.
// (R12) Reevaluate at frame, grant highest request.
// (R13) Higher request preempts grant next clock.
// (R14) Previous initiator drops to lowest priority.
// (R15) Sixteen idle granted cycles: withdraw, bar until release.
// (R16) Idle bus: gap between grants; busy swaps.
// (R17) Strap high: gnt0 requests, req0 grants.
// (R18) External mode: park when grant and idle.
// (R19) External mode drives grants 8 to 1 high.
// (R20) Park secondary at last master; bridge after reset.
// (R21) Idle means frame and ready high; one grant.
module pba_top
    import pba_pkg::*;
#(
    parameter int N_EXT = PBA_EXT_MASTERS
)
(
    input wire logic ref_clk,                  // Bus clock, 100 MHz.
    input wire logic nrst,                     // Asynchronous reset, active low.
    input wire logic arb_ext_strap,            // High selects an external secondary arbiter.
    // ============================================================
    // Primary bus side.
    input wire logic p_gnt_n,                  // Primary grant, active low.
    input wire logic p_frame_in_n,             // Primary frame seen on the bus.
    input wire logic p_irdy_in_n,              // Primary initiator ready seen on the bus.
    output logic p_req_n,                      // Primary request, active low.
    output logic p_start,                      // Pulse: drive primary frame this cycle.
    output logic p_ad_oe,                      // Primary address/command drive enable.
    output logic p_par_oe,                     // Primary parity drive enable.
    // ============================================================
    // Upstream queue status.
    input wire logic up_posted,                // Upstream posted write being accepted.
    input wire logic s_devsel_n,               // Secondary target select, active low.
    input wire logic up_dly_ready,             // Delayed entry queued, retried and at head.
    input wire logic p_done,                   // Primary transaction finished.
    // ============================================================
    // Secondary bus side.
    input wire logic [N_EXT-1:0] s_req_n,      // Secondary requests, active low.
    input wire logic s_frame_in_n,             // Secondary frame seen on the bus.
    input wire logic s_irdy_in_n,              // Secondary initiator ready seen on the bus.
    input wire logic dn_pending,               // Bridge has a downstream transaction.
    output logic [N_EXT-1:0] s_gnt_n,          // Secondary grants, active low.
    output logic s_start,                      // Pulse: bridge starts secondary frame.
    output logic s_ad_oe,                      // Secondary address/command drive enable.
    output logic s_par_oe,                     // Secondary parity drive enable.
    // ============================================================
    // Register port.
    input wire logic [PBA_ADDR_W-1:0] reg_addr, // Register address.
    input wire logic [31:0] reg_wdata,         // Write data.
    input wire logic reg_wr,                   // Write strobe.
    input wire logic reg_rd,                   // Read strobe.
    output logic [31:0] reg_rdata              // Read data, one cycle after the strobe.
);
    localparam int N = N_EXT + 1;
    initial
    begin
        if (N_EXT != PBA_EXT_MASTERS)
            $error("pba_top: master count fixed by the reset group map");
    end

    pba_arb_if #(.N(N)) arb_c ();

    // ============================================================
    // Primary requester.
    pba_preq_t pst_r, pst_nxt;
    logic p_req_r, p_req_nxt;
    logic p_start_r, p_start_nxt;
    logic posted_r, posted_nxt;            // Posted write waiting for devsel.
    logic p_gnt_d_r;                       // Grant seen in the previous cycle.
    logic p_idle;
    logic p_park;

    always_comb
    begin
        p_idle = p_frame_in_n && p_irdy_in_n;
        p_park = !p_gnt_n && !p_req_r && p_idle && pst_r != PBA_P_RUN; // (R4)
    end

    // A posted request is armed by the write and fires the cycle after devsel.
    always_comb
    begin
        pst_nxt = pst_r;
        p_req_nxt = p_req_r;
        p_start_nxt = 1'b0;
        posted_nxt = posted_r || up_posted;
        case (pst_r)
            PBA_P_IDLE:
            begin
                if (posted_r && !s_devsel_n)
                begin
                    p_req_nxt = 1'b1; // (R1)
                    posted_nxt = 1'b0;
                    pst_nxt = PBA_P_REQ;
                end
                else if (up_dly_ready)
                begin
                    p_req_nxt = 1'b1; // (R2)
                    pst_nxt = PBA_P_REQ;
                end
            end
            PBA_P_REQ:
            begin
                // Grant already held last cycle (parked) or newly seen: start next cycle.
                if (!p_gnt_n && p_idle && (p_gnt_d_r || p_req_r)) // (R3) (R6)
                begin
                    p_start_nxt = 1'b1;
                    pst_nxt = PBA_P_RUN;
                end
            end
            PBA_P_RUN:
            begin
                p_req_nxt = 1'b0;
                if (p_done)
                    pst_nxt = PBA_P_IDLE;
            end
            default:
                pst_nxt = PBA_P_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pst_r <= PBA_P_IDLE;
            p_req_r <= 1'b0;
            p_start_r <= 1'b0;
            posted_r <= 1'b0;
            p_gnt_d_r <= 1'b0;
        end
        else
        begin
            pst_r <= pst_nxt;
            p_req_r <= p_req_nxt;
            p_start_r <= p_start_nxt;
            posted_r <= posted_nxt;
            p_gnt_d_r <= !p_gnt_n;
        end
    end

    // Grant loss drops park, so drivers release the next cycle.
    pba_park_drv u_ppark (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .park(p_park), // (R5)
        .ad_oe(p_ad_oe),
        .par_oe(p_par_oe)
    );

    // ============================================================
    // Secondary arbitration.
    logic [N-1:0] group_r, group_nxt;      // Group bits, software written.
    logic s_busy, s_idle;
    logic s_frame_d_r;                     // Previous frame level for start detect.
    logic [N_EXT-1:0] s_gnt_r, s_gnt_nxt;
    logic s_start_r, s_start_nxt;
    logic ext_req_r, ext_req_nxt;          // Bridge request in external mode.
    logic s_park;

    always_comb
    begin
        s_idle = s_frame_in_n && s_irdy_in_n; // (R21)
        s_busy = !s_idle;
        arb_c.req = {dn_pending, ~s_req_n}; // (R8)
        arb_c.group = group_r; // (R10)
        arb_c.start = !s_frame_in_n && s_frame_d_r;
        arb_c.busy = s_busy;
    end

    pba_sec_arb #(.N(N)) u_sarb (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .a(arb_c.arb)
    );

    // Grant pins and the bridge's own start in either mode.
    always_comb
    begin
        s_gnt_nxt = '1;
        ext_req_nxt = 1'b0;
        s_start_nxt = 1'b0;
        if (arb_ext_strap)
        begin
            ext_req_nxt = dn_pending && !s_start_r;
            s_gnt_nxt[0] = !ext_req_nxt; // (R17) (R19)
            s_start_nxt = ext_req_r && !s_req_n[0] && s_idle; // (R17)
            s_park = !s_req_n[0] && !ext_req_r && s_idle; // (R18)
        end
        else
        begin
            s_gnt_nxt = ~arb_c.gnt[N_EXT-1:0]; // (R8)
            s_start_nxt = arb_c.gnt[N-1] && dn_pending && s_idle && !s_start_r;
            s_park = arb_c.gnt[N-1] && !dn_pending && s_idle; // (R20)
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_gnt_r <= '1;
            ext_req_r <= 1'b0;
            s_start_r <= 1'b0;
            s_frame_d_r <= 1'b1;
        end
        else
        begin
            s_gnt_r <= s_gnt_nxt;
            ext_req_r <= ext_req_nxt;
            s_start_r <= s_start_nxt;
            s_frame_d_r <= s_frame_in_n;
        end
    end

    pba_park_drv u_spark (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .park(s_park),
        .ad_oe(s_ad_oe),
        .par_oe(s_par_oe)
    );

    // ============================================================
    // Register port: group bits, status, last owner.
    logic [31:0] rdata_r, rdata_nxt;

    always_comb
    begin
        group_nxt = group_r;
        rdata_nxt = '0;
        if (reg_wr && reg_addr == PBA_REG_GROUP)
            group_nxt = reg_wdata[N-1:0]; // (R10)
        if (reg_rd)
        begin
            case (reg_addr)
                PBA_REG_GROUP: rdata_nxt = 32'(group_r);
                PBA_REG_STATUS: rdata_nxt = {28'h0, arb_ext_strap, p_req_r, s_busy, p_park};
                PBA_REG_OWNER: rdata_nxt = {28'h0, arb_c.owner};
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            group_r <= PBA_GROUP_RST; // (R11)
            rdata_r <= '0;
        end
        else
        begin
            group_r <= group_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign p_req_n = !p_req_r;
    assign p_start = p_start_r;
    assign s_gnt_n = s_gnt_r;
    assign s_start = s_start_r;
    assign reg_rdata = rdata_r;

    a_posted_req: assert property (@(posedge ref_clk) disable iff (!nrst)
        (pst_r == PBA_P_IDLE && posted_r && !s_devsel_n) |=> p_req_r) // (R1)
        else $error("posted write request late");
    a_gnt_start: assert property (@(posedge ref_clk) disable iff (!nrst)
        (pst_r == PBA_P_REQ && !p_gnt_n && p_idle && p_req_r) |=> p_start_r) // (R3)
        else $error("primary start missed");
    a_park_cond: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(p_ad_oe) |-> $past(!p_gnt_n && !p_req_r && p_idle)) // (R4)
        else $error("primary parked without grant");
    a_park_release: assert property (@(posedge ref_clk) disable iff (!nrst)
        (p_ad_oe && p_gnt_n) |=> !p_ad_oe && !p_par_oe) // (R5)
        else $error("primary drivers held after grant loss");
    a_ext_unused: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(arb_ext_strap) |-> (s_gnt_r[N_EXT-1:1] == '1)) // (R19)
        else $error("unused grants not high");
    a_ext_start: assert property (@(posedge ref_clk) disable iff (!nrst)
        (arb_ext_strap && ext_req_r && !s_req_n[0] && s_idle) |=> s_start_r) // (R17)
        else $error("external grant start missed");
    a_group_rst: assert property (@(posedge ref_clk) $rose(nrst) |-> group_r == PBA_GROUP_RST) // (R11)
        else $error("group reset value wrong");
endmodule // pba_top
`default_nettype wire

/* bench/pba_parb.sv */
`default_nettype none
// ============================================================
// Primary arbiter model: grants a held request after a delay, or parks.
module pba_parb
(
    input wire logic ref_clk,   // Bus clock.
    input wire logic nrst,      // Reset, active low.
    input wire logic req_n,     // Bridge request, active low.
    input wire logic park,      // Grant the bridge with no request.
    input wire logic [1:0] dly, // Extra cycles before a grant.
    output logic gnt_n          // Grant, active low.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_r; // Cycles the request has waited.
    // The grant moves only after an edge, so a slow arbiter is modelled too.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_r <= 2'h0;
            gnt_n <= 1'b1;
        end
        else
        begin
            cnt_r <= req_n ? 2'h0 : cnt_r + 2'h1;
            gnt_n <= !(park || (!req_n && cnt_r >= dly));
        end
    end
endmodule // pba_parb
`default_nettype wire

/* bench/pba_top_bench.sv */
`default_nettype none
// ============================================================
// Self-checking bench of the arbitration block.
module pba_top_bench;
    import pba_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, nrst, arb_ext_strap, p_gnt_n, p_req_n, p_start, p_ad_oe, p_par_oe, park;
    logic up_posted, s_devsel_n, up_dly_ready, p_done, s_frame_in_n, dn_pending, s_start;
    logic s_ad_oe, s_par_oe, reg_wr, reg_rd;
    logic [1:0] dly;
    logic [8:0] s_req_n, s_gnt_n;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    int n_mismatch = 0;
    int samples_checked = 0;
    pba_top u_pba_top (.ref_clk, .nrst, .arb_ext_strap, .p_gnt_n, .p_frame_in_n(1'b1),
        .p_irdy_in_n(1'b1), .p_req_n, .p_start, .p_ad_oe, .p_par_oe, .up_posted, .s_devsel_n,
        .up_dly_ready, .p_done, .s_req_n, .s_frame_in_n, .s_irdy_in_n(1'b1), .dn_pending,
        .s_gnt_n, .s_start, .s_ad_oe, .s_par_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    pba_parb u_pba_parb (.ref_clk, .nrst, .req_n(p_req_n), .park, .dly, .gnt_n(p_gnt_n));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = !ref_clk;
    end
    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One register access; read data stand only in the cycle after the strobe.
    task automatic rg(input logic w, input logic [3:0] a, input logic [31:0] d);
        cy(1);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        cy(1);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        if (!w) chk(reg_rdata, d);
    endtask
    // Waits a bounded time for the primary grant; a hang ends the run.
    task automatic start_done();
        for (int i = 0; i < 9 && p_gnt_n !== 1'b0; i++)
        begin
            cy(1);
            #1;
        end
        if (p_gnt_n !== 1'b0)
        begin
            n_mismatch++;
            end_of_test();
        end
        cy(1);
        up_dly_ready <= 1'b0;
        #1 chk({p_start, p_req_n}, 2'b10);
        cy(1);
        p_done <= 1'b1;
        cy(1);
        p_done <= 1'b0;
    endtask
    task automatic t_regs();
        #1 chk({p_req_n, p_ad_oe, p_par_oe, s_gnt_n}, 12'h9ff);
        rg(1'b0, PBA_REG_GROUP, 32'h200);
        rg(1'b1, PBA_REG_GROUP, 32'h3ff);
        rg(1'b0, PBA_REG_GROUP, 32'h3ff);
        rg(1'b1, PBA_REG_GROUP, 32'h200);
        rg(1'b0, 4'hf, 32'h0);
    endtask
    task automatic t_posted();
        dly <= 2'h0;
        up_posted <= 1'b1;
        cy(1);
        up_posted <= 1'b0;
        s_devsel_n <= 1'b0;
        #1 chk(p_req_n, 1'b1);
        cy(1);
        s_devsel_n <= 1'b1;
        #1 chk(p_req_n, 1'b0);
        start_done();
    endtask
    task automatic t_delayed();
        dly <= 2'h2;
        cy(3);
        #1 chk(p_req_n, 1'b1);
        up_dly_ready <= 1'b1;
        cy(1);
        #1 chk(p_req_n, 1'b0);
        start_done();
    endtask
    // Parking: address first, parity a cycle later, all off after grant loss.
    task automatic t_park();
        park <= 1'b1;
        cy(2);
        #1 chk({p_ad_oe, p_par_oe}, 2'b10);
        cy(1);
        #1 chk({p_ad_oe, p_par_oe}, 2'b11);
        park <= 1'b0;
        cy(2);
        #1 chk({p_ad_oe, p_par_oe}, 2'b00);
    endtask
    task automatic t_sec();
        s_req_n[1] <= 1'b0;
        cy(1);
        #1 chk(s_gnt_n, 9'h1ff);
        cy(2);
        #1 chk(s_gnt_n, 9'h1fd);
        cy(15);
        #1 chk(s_gnt_n, 9'h1fd);
        cy(1);
        #1 chk(s_gnt_n, 9'h1ff);
        s_req_n[1] <= 1'b1;
        cy(1);
        s_req_n[1] <= 1'b0;
        cy(3);
        #1 chk(s_gnt_n, 9'h1fd);
        // One frame start makes master 1 the last initiator, so the bridge wins next.
        s_frame_in_n <= 1'b0;
        cy(1);
        s_frame_in_n <= 1'b1;
        dn_pending <= 1'b1;
        cy(2);
        #1 chk(s_gnt_n, 9'h1ff);
        dn_pending <= 1'b0;
        s_req_n <= 9'h1ff;
    endtask
    task automatic t_ext();
        nrst <= 1'b0;
        arb_ext_strap <= 1'b1;
        cy(2);
        nrst <= 1'b1;
        dn_pending <= 1'b1;
        cy(2);
        #1 chk(s_gnt_n, 9'h1fe);
        s_req_n[0] <= 1'b0;
        cy(1);
        #1 chk({s_start, s_gnt_n[8:1]}, 9'h1ff);
    endtask
    initial
    begin
        {nrst, arb_ext_strap, park, up_posted, up_dly_ready, p_done, dn_pending, reg_wr, reg_rd} = '0;
        {s_devsel_n, s_frame_in_n, s_req_n, reg_addr, reg_wdata, dly} = '1;
        cy(6);
        nrst <= 1'b1;
        cy(1);
        t_regs();
        t_posted();
        t_delayed();
        t_park();
        t_sec();
        t_ext();
        end_of_test();
    end
endmodule // pba_top_bench
`default_nettype wire
